//--- tb/sar_adc_result_and_control_tb.sv
module sar_adc_result_and_control_tb;
  timeunit 1ns;
  timeprecision 1ps;
  `define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin n_fail++; \
    $display("FAIL t=%0t got=%h exp=%h", $time, g, e); end end
  logic       sys_clk = 0, srst = 1, sfr_write = 0, sfr_read = 0, sfr_bit_write = 0, sfr_bit_value = 0;
  logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata, d;
  logic [3:0] sfr_page = 4'h0;
  logic [2:0] sfr_bit_index = 3'h0;
  logic [4:0] src = 5'h00;
  logic [9:0] code = 10'h2b5, sar_result;
  logic       sfr_hit, converter_powered, track_active, sar_step, gain_one, conversion_done_pulse;
  int         n_fail = 0, tests_run = 0, ticks = 0, c0, c1, i;

  sar_converter_control i_dut (.sys_clk, .srst, .sfr_addr, .sfr_page, .sfr_write, .sfr_read, .sfr_wdata,
    .sfr_bit_write, .sfr_bit_index, .sfr_bit_value, .sfr_rdata, .sfr_hit, .timer0_overflow(src[0]),
    .timer2_overflow(src[1]), .timer1_overflow(src[2]), .external_convert_pin(src[3]),
    .timer3_overflow(src[4]), .window_compare_event(1'b0), .sar_result, .converter_powered,
    .track_active, .sar_step, .gain_one, .conversion_done_pulse);
  sar_analog_model i_sar (.track_active, .sar_step, .code, .sar_result);

  initial forever #2 sys_clk = ~sys_clk;
  always @(posedge sys_clk) if (++ticks == 20000) begin
    n_fail++;
    test_done();
  end

  task automatic test_done();
    if (n_fail == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Strobe drops for one full edge so back-to-back calls never re-raise it in the same step
  task automatic wr(input [7:0] a, input [3:0] p, input [7:0] v);
    {sfr_addr, sfr_page, sfr_wdata, sfr_write} = {a, p, v, 1'b1};
    @(posedge sys_clk) #1 sfr_write = 0;
    @(posedge sys_clk) #1;
  endtask
  task automatic bw(input [2:0] b, input v);
    {sfr_addr, sfr_bit_index, sfr_bit_value, sfr_bit_write} = {8'he8, b, v, 1'b1};
    @(posedge sys_clk) #1 sfr_bit_write = 0;
    @(posedge sys_clk) #1;
  endtask
  // Reads have no side effect, so the qualifier stays high once raised
  task automatic rd(input [7:0] a, input [3:0] p);
    {sfr_addr, sfr_page, sfr_read} = {a, p, 1'b1};
    #0.2 d = sfr_rdata;
  endtask
  task automatic conv(input [7:0] ctl, output int n);
    wr(8'he8, 4'h3, ctl);
    if (ctl[2:0] == 3'h0) begin
      bw(3'h4, 1'b1);
      rd(8'he8, 4'h3);
      if (!ctl[6]) `CHK(d[4], 1'b1)
    end else begin
      src[ctl[2:0] - 3'h1] = 1'b1;
      @(posedge sys_clk) #1 src = 5'h00;
    end
    n = 0;
    rd(8'he8, 4'h3);
    while (!d[5] && n < 200) begin
      @(posedge sys_clk) #1 n++;
      rd(8'he8, 4'h3);
    end
    `CHK(d, ctl | 8'h20)
  endtask

  task automatic t_reset();
    rd(8'he8, 4'h5); `CHK(d, 8'h00)
    rd(8'hbc, 4'hf); `CHK(d, 8'hf9)
    wr(8'hbd, 4'h0, 8'h5a);
    wr(8'hbe, 4'h1, 8'h33);
    rd(8'hbd, 4'h0); `CHK(d, 8'h5a)
    rd(8'hbe, 4'h0); `CHK(d, 8'h00)
    `CHK(converter_powered, 1'b0)
    `CHK(gain_one, 1'b1)
  endtask
  task automatic t_format();
    logic [7:0] cfg [4] = '{8'h01, 8'h05, 8'h03, 8'h07};
    for (int k = 0; k < 4; k++) begin
      wr(8'hbc, 4'hf, cfg[k]);
      `CHK(gain_one, cfg[k][0])
      code = code + 10'h0d3;
      conv(8'h80, c0);
      rd(8'hbe, 4'h0); `CHK(d, (cfg[k][2] | cfg[k][1]) ? code[9:2] : {6'h00, code[9:8]})
      rd(8'hbd, 4'h0); `CHK(d, cfg[k][1] ? 8'h00 : cfg[k][2] ? {code[1:0], 6'h00} : code[7:0])
    end
  endtask
  task automatic t_refuse();
    int bad [3] = '{1, 6, 7};
    foreach (bad[k]) begin
      wr(8'he8, 4'h3, 8'h90 | bad[k][7:0]);
      repeat (20) @(posedge sys_clk);
      #1 rd(8'he8, 4'h3); `CHK(d, 8'h80 | bad[k][7:0])
    end
  endtask
  task automatic t_delay();
    conv(8'h80, c0);
    conv(8'hc0, c1);
    `CHK(c1 - c0, 3)
  endtask
  task automatic t_off();
    bw(3'h7, 1'b0);
    `CHK(converter_powered, 1'b0)
    bw(3'h4, 1'b1);
    repeat (20) @(posedge sys_clk);
    #1 rd(8'he8, 4'h7); `CHK(d, 8'h60)
  endtask

  initial begin
    repeat (12) @(posedge sys_clk);
    #1 srst = 0;
    t_reset();
    t_format();
    for (i = 1; i < 6; i++) conv(8'h80 | i[7:0], c0);
    t_refuse();
    t_delay();
    t_off();
    test_done();
  end
endmodule

//--- tb/sar_analog_model.sv
module sar_analog_model (
  input  wire logic       track_active,
  input  wire logic       sar_step,
  input  wire logic [9:0] code,
  output      logic [9:0] sar_result
);
  timeunit 1ns;
  timeprecision 1ps;
  // Inverse code off the step, so a sample taken at the wrong time shows up
  assign sar_result = (sar_step && !track_active) ? code : ~code;
endmodule

//--- tb/sar_ctl_properties.sv
module sar_ctl_properties (
  input wire logic       sys_clk,
  input wire logic       srst,
  input wire logic [7:0] sfr_addr,
  input wire logic [3:0] sfr_page,
  input wire logic       sfr_read,
  input wire logic [7:0] sfr_rdata,
  input wire logic       sfr_hit,
  input wire logic       converter_powered,
  input wire logic       track_active,
  input wire logic       sar_step,
  input wire logic       conversion_done_pulse
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (srst);
  logic [4:0] steps_ff;
  always @(posedge sys_clk) begin
    if (srst || conversion_done_pulse || !converter_powered)
      steps_ff <= 5'h00;
    else
      steps_ff <= steps_ff + {4'h0, sar_step};
  end
  off_quiet_a: assert property (!converter_powered |-> !sar_step && !track_active)
    else $error("activity while disabled");
  step_track_a: assert property (sar_step |-> !track_active)
    else $error("tracking during conversion");
  step_count_a: assert property (conversion_done_pulse |-> steps_ff inside {5'h08, 5'h0b})
    else $error("wrong step count");
  done_cause_a: assert property (conversion_done_pulse |-> $past(sar_step) || $past(sar_step, 2))
    else $error("done without conversion");
  done_single_a: assert property (conversion_done_pulse |=> !conversion_done_pulse)
    else $error("done pulse too long");
  unmapped_zero_a: assert property (sfr_read && !sfr_hit |-> sfr_rdata == 8'h00)
    else $error("unmapped read not zero");
  ctl_any_page_a: assert property (sfr_addr == 8'he8 |-> sfr_hit)
    else $error("control missed");
  result_page_a: assert property (sfr_addr inside {8'hbd, 8'hbe} |-> sfr_hit == (sfr_page == 4'h0))
    else $error("result page decode");
  cover property (conversion_done_pulse);
  cover property (sar_step);
  cover property (sfr_read && !sfr_hit);
endmodule

bind sar_converter_control sar_ctl_properties i_props (.sys_clk, .srst, .sfr_addr, .sfr_page, .sfr_read,
  .sfr_rdata, .sfr_hit, .converter_powered, .track_active, .sar_step, .conversion_done_pulse);

//--- verilog/sar_clock_divider.v
module sar_clock_divider (
  input  wire       sys_clk,
  input  wire       srst,
  input  wire       run,
  input  wire [4:0] divide_by_minus_one,
  output wire       sar_tick
);
  reg [4:0] count_ff;
  wire [4:0] nxt_count;

  // One tick every (divider + 1) system clocks
  assign sar_tick  = run && (count_ff >= divide_by_minus_one); // [R16]
  assign nxt_count = (!run || sar_tick) ? 5'h00 : count_ff + 5'h01;

  always @(posedge sys_clk) begin
    if (srst) begin
      count_ff <= 5'h00;
    end else begin
      count_ff <= nxt_count;
    end
  end
endmodule

//--- verilog/sar_converter_control.v
`include "sar_ctl_map.vh"

// Behaviour
// R1: Right justified: high byte bits 7..2 zero, bits 1..0 hold result msbs.
// R2: Left justified 10-bit: high byte holds eight msbs of result.
// R3: Eight-bit mode ignores justification; high byte holds whole 8-bit result.
// R4: Right justified: low byte holds lower eight result bits.
// R5: Left justified: low byte bits 7..6 hold two lsbs, rest zero.
// R6: Eight-bit mode: low byte reads all zeros.
// R7: Enable 0 means shutdown; enable 1 means active and accepting triggers.
// R8: Normal track mode enabled: track continuously except during conversion. Code: with pin trigger, tracks only while the pin is low.
// R9: Normal track mode: conversion starts at once on selected trigger.
// R10: Delayed track mode: three extra SAR clocks of tracking before converting.
// R11: Done flag reads 0 until conversion completes; set on completion.
// R12: Control register on every page, bit addressable; result bytes on page 0.
// R13: Trigger codes: software, timer0, timer2, timer1, pin, timer3; 11x reserved.
// R14: Busy write 1 starts only with software trigger; busy reads 1 while converting.
// R15: Eight-bit select 0 gives 10-bit, 1 gives 8-bit, justification ignored.
// R16: SAR clock is system clock divided by divider field plus one.
// R17: Both result bytes update in same cycle as done flag sets.
// R18: Busy clears in the same cycle the done flag sets.
module sar_converter_control #(
  parameter RESULT_WIDTH = 10
) (
  input  wire                    sys_clk,
  input  wire                    srst,
  input  wire [7:0]              sfr_addr,
  input  wire [3:0]              sfr_page,
  input  wire                    sfr_write,
  input  wire                    sfr_read,
  input  wire [7:0]              sfr_wdata,
  input  wire                    sfr_bit_write,
  input  wire [2:0]              sfr_bit_index,
  input  wire                    sfr_bit_value,
  output reg  [7:0]              sfr_rdata,
  output wire                    sfr_hit,
  input  wire                    timer0_overflow,
  input  wire                    timer1_overflow,
  input  wire                    timer2_overflow,
  input  wire                    timer3_overflow,
  input  wire                    external_convert_pin,
  input  wire                    window_compare_event,
  input  wire [RESULT_WIDTH-1:0] sar_result,
  output wire                    converter_powered,
  output wire                    track_active,
  output wire                    sar_step,
  output wire                    gain_one,
  output wire                    conversion_done_pulse
);
  localparam ST_IDLE    = 2'h0;
  localparam ST_DELAY   = 2'h1;
  localparam ST_CONVERT = 2'h2;

  reg  [7:0] control_ff;
  reg  [7:0] config_ff;
  reg  [7:0] result_low_ff;
  reg  [7:0] result_high_ff;
  reg  [1:0] state_ff;
  reg  [1:0] delay_cnt_ff;
  reg  [4:0] conv_cnt_ff;
  reg        pin_meta_ff;
  reg        pin_sync_ff;
  reg        pin_prev_ff;
  reg        done_pulse_ff;

  reg  [1:0] nxt_state;
  reg  [1:0] nxt_delay_cnt;
  reg  [4:0] nxt_conv_cnt;
  reg  [7:0] nxt_control;
  reg  [7:0] nxt_config;
  reg  [7:0] nxt_result_low;
  reg  [7:0] nxt_result_high;
  reg        trigger;
  reg        finish;

  wire       sar_tick;
  wire       enabled     = control_ff[`CTL_ENABLE_BIT];
  wire       delayed     = control_ff[`CTL_DELAYED_BIT];
  wire [2:0] trig_sel    = control_ff[`CTL_TRIG_LSB+2:`CTL_TRIG_LSB];
  wire       eight_bit   = config_ff[`CFG_8BIT_BIT];
  wire       left_just   = config_ff[`CFG_LJST_BIT];
  wire       ctl_sel     = (sfr_addr == `ADDR_CONV_CONTROL); // [R12]
  wire       cfg_sel     = (sfr_addr == `ADDR_CONV_CONFIG) && (sfr_page == `PAGE_CONFIG);
  wire       low_sel     = (sfr_addr == `ADDR_RESULT_LOW) && (sfr_page == `PAGE_RESULTS); // [R12]
  wire       high_sel    = (sfr_addr == `ADDR_RESULT_HIGH) && (sfr_page == `PAGE_RESULTS); // [R12]
  wire       pin_rise    = pin_sync_ff && !pin_prev_ff;
  wire [4:0] conv_len    = eight_bit ? `CONV_SARCLK_8BIT : `CONV_SARCLK_10BIT; // [R15]

  // Control register image after a byte or single-bit write
  function [7:0] apply_write;
    input [7:0] cur;
    input       byte_wr;
    input [7:0] data;
    input       bit_wr;
    input [2:0] idx;
    input       val;
    reg   [7:0] tmp;
    begin
      tmp = cur;
      if (byte_wr) begin
        tmp = data;
      end else if (bit_wr) begin
        tmp[idx] = val;
      end
      apply_write = tmp;
    end
  endfunction

  // High/low result bytes from the raw code and format bits
  function [15:0] format_result;
    input [RESULT_WIDTH-1:0] code;
    input                    ljst;
    input                    mode8;
    begin
      if (mode8) begin
        format_result = {code[RESULT_WIDTH-1:RESULT_WIDTH-8], 8'h00}; // [R3] [R6]
      end else if (ljst) begin
        format_result = {code[9:2], code[1:0], 6'h00}; // [R2] [R5]
      end else begin
        format_result = {6'h00, code[9:8], code[7:0]}; // [R1] [R4]
      end
    end
  endfunction

  sar_clock_divider u_div (
    .sys_clk             (sys_clk),
    .srst                (srst),
    .run                 (enabled && (state_ff != ST_IDLE)),
    .divide_by_minus_one (config_ff[`CFG_DIV_LSB+4:`CFG_DIV_LSB]),
    .sar_tick            (sar_tick)
  );

  wire       ctl_wr      = ctl_sel && sfr_write;
  wire       ctl_bit_wr  = ctl_sel && sfr_bit_write;
  wire [7:0] ctl_written = apply_write(control_ff, ctl_wr, sfr_wdata, ctl_bit_wr, sfr_bit_index, sfr_bit_value);
  // Busy write-1 seen on either write path
  wire       busy_wr1    = ctl_written[`CTL_BUSY_BIT] && (ctl_wr || (ctl_bit_wr && sfr_bit_index == 3'h4));

  always @* begin
    case (trig_sel) // [R13]
      `TRIG_SOFTWARE: trigger = busy_wr1; // [R14]
      `TRIG_TIMER0:   trigger = timer0_overflow;
      `TRIG_TIMER2:   trigger = timer2_overflow;
      `TRIG_TIMER1:   trigger = timer1_overflow;
      `TRIG_EXT_PIN:  trigger = pin_rise;
      `TRIG_TIMER3:   trigger = timer3_overflow;
      default:        trigger = 1'b0;
    endcase
  end

  always @* begin
    nxt_state     = state_ff;
    nxt_delay_cnt = delay_cnt_ff;
    nxt_conv_cnt  = conv_cnt_ff;
    finish        = 1'b0;
    case (state_ff)
      ST_IDLE: begin
        if (enabled && trigger) begin // [R7]
          nxt_conv_cnt  = 5'h00;
          nxt_delay_cnt = 2'h0;
          nxt_state     = delayed ? ST_DELAY : ST_CONVERT; // [R9] [R10]
        end
      end
      ST_DELAY: begin
        if (sar_tick) begin
          nxt_delay_cnt = delay_cnt_ff + 2'h1;
          if (delay_cnt_ff == `DELAYED_TRACK_SARCLK - 2'h1) begin // [R10]
            nxt_state = ST_CONVERT;
          end
        end
      end
      ST_CONVERT: begin
        if (sar_tick) begin
          nxt_conv_cnt = conv_cnt_ff + 5'h01;
          if (conv_cnt_ff == conv_len - 5'h01) begin
            finish    = 1'b1;
            nxt_state = ST_IDLE;
          end
        end
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
    // Disabling aborts any conversion in flight
    if (!enabled) begin
      nxt_state = ST_IDLE; // [R7]
      finish    = 1'b0;
    end
  end

  always @* begin
    nxt_control = ctl_written;
    // Busy is hardware state; software write only triggers
    nxt_control[`CTL_BUSY_BIT] = (nxt_state == ST_CONVERT) || (nxt_state == ST_DELAY); // [R14] [R18]
    // Hardware set wins over software clear
    if (finish) begin
      nxt_control[`CTL_DONE_BIT] = 1'b1; // [R11]
    end
    if (window_compare_event) begin
      nxt_control[`CTL_WINDOW_BIT] = 1'b1;
    end
    nxt_config = (cfg_sel && sfr_write) ? sfr_wdata : config_ff;
    nxt_result_low  = (low_sel && sfr_write) ? sfr_wdata : result_low_ff;
    nxt_result_high = (high_sel && sfr_write) ? sfr_wdata : result_high_ff;
    if (finish) begin
      {nxt_result_high, nxt_result_low} = format_result(sar_result, left_just, eight_bit); // [R17]
    end
  end

  always @(posedge sys_clk) begin
    if (srst) begin
      control_ff     <= `CTL_RESET;
      config_ff      <= `CFG_RESET;
      result_low_ff  <= 8'h00;
      result_high_ff <= 8'h00;
      state_ff       <= ST_IDLE;
      delay_cnt_ff   <= 2'h0;
      conv_cnt_ff    <= 5'h00;
      pin_meta_ff    <= 1'b0;
      pin_sync_ff    <= 1'b0;
      pin_prev_ff    <= 1'b0;
      done_pulse_ff  <= 1'b0;
    end else begin
      control_ff     <= nxt_control;
      config_ff      <= nxt_config;
      result_low_ff  <= nxt_result_low;
      result_high_ff <= nxt_result_high;
      state_ff       <= nxt_state;
      delay_cnt_ff   <= nxt_delay_cnt;
      conv_cnt_ff    <= nxt_conv_cnt;
      pin_meta_ff    <= external_convert_pin;
      pin_sync_ff    <= pin_meta_ff;
      pin_prev_ff    <= pin_sync_ff;
      done_pulse_ff  <= finish;
    end
  end

  always @* begin
    sfr_rdata = 8'h00;
    if (sfr_read) begin
      if (ctl_sel) begin
        sfr_rdata = control_ff;
      end else if (cfg_sel) begin
        sfr_rdata = config_ff;
      end else if (low_sel) begin
        sfr_rdata = result_low_ff;
      end else if (high_sel) begin
        sfr_rdata = result_high_ff;
      end
    end
  end

  assign sfr_hit               = ctl_sel || cfg_sel || low_sel || high_sel;
  assign converter_powered     = enabled; // [R7]
  // Pin-triggered normal mode tracks only while the pin is low
  assign track_active          = enabled && (state_ff != ST_CONVERT) &&
                                 (delayed || trig_sel != `TRIG_EXT_PIN || !pin_sync_ff); // [R8]
  assign sar_step              = sar_tick && (state_ff == ST_CONVERT);
  assign gain_one              = config_ff[`CFG_GAIN_BIT];
  assign conversion_done_pulse = done_pulse_ff;
endmodule

//--- verilog/sar_ctl_map.vh
`ifndef SAR_CTL_MAP_VH
`define SAR_CTL_MAP_VH

// Register addresses on the special-function bus
`define ADDR_RESULT_LOW      8'hbd
`define ADDR_RESULT_HIGH     8'hbe
`define ADDR_CONV_CONTROL    8'he8
`define ADDR_CONV_CONFIG     8'hbc
`define PAGE_RESULTS         4'h0
`define PAGE_CONFIG          4'hf

// Control register fields
`define CTL_ENABLE_BIT       7
`define CTL_DELAYED_BIT      6
`define CTL_DONE_BIT         5
`define CTL_BUSY_BIT         4
`define CTL_WINDOW_BIT       3
`define CTL_TRIG_LSB         0
`define CTL_RESET            8'h00

// Config register fields
`define CFG_DIV_LSB          3
`define CFG_LJST_BIT         2
`define CFG_8BIT_BIT         1
`define CFG_GAIN_BIT         0
`define CFG_RESET            8'hf9

// Trigger source codes
`define TRIG_SOFTWARE        3'h0
`define TRIG_TIMER0          3'h1
`define TRIG_TIMER2          3'h2
`define TRIG_TIMER1          3'h3
`define TRIG_EXT_PIN         3'h4
`define TRIG_TIMER3          3'h5

// Timing in SAR clocks
`define DELAYED_TRACK_SARCLK 2'h3
`define CONV_SARCLK_10BIT    5'h0b
`define CONV_SARCLK_8BIT     5'h08

`endif
